// ---- pkg/cms_pkg.sv ----
package cms_pkg;

  // ****************************************
  // Conversion timing
  // ****************************************
  localparam int MOD_DIV = 6;
  localparam int OSR = 64;
  localparam int SINC_ORDER = 5;
  localparam int WORD_CYC = MOD_DIV * OSR;
  localparam int SETTLE_WORDS = 5;

  // ****************************************
  // Data widths
  // ****************************************
  localparam int RESULT_W = 24;
  localparam int ACC_W = 31;
  localparam int RES_LSB = 6;
  localparam int PTR_W = 8;

  // ****************************************
  // Ready phase lengths, in mclk cycles
  // ****************************************
  localparam int READY_LOW_CYC = 4;
  localparam int READY_HIGH_CYC = 2;

  // ****************************************
  // Reset, saturation and sign values, and phase codes
  // ****************************************
  localparam logic [23:0] RESULT_RST = 24'h000000;
  localparam logic [23:0] RESULT_SAT = 24'hFFFFFF;
  localparam logic [23:0] RESULT_SIGN = 24'h800000;
  localparam logic [1:0] SEL_RST = 2'h0;
  localparam logic [3:0] CH_ONEHOT_RST = 4'h1;

  typedef enum logic [3:0] {
    CMS_IDLE  = 4'h1,
    CMS_LOW   = 4'h2,
    CMS_HIGH  = 4'h4,
    CMS_SHIFT = 4'h8
  } cms_phase_t;

endpackage

// ---- core/cms_sequencer.sv ----
`timescale 1ns/1ps
// Summary of operation
// [R1] Modulator tick is system clock divided by six
// [R2] One output word per 64 modulator ticks
// [R3] Fifth-order sinc decimator loads output word register
// [R4] Results are 24-bit words
// [R5] Result line pulses low after each load once settling completes
// [R6] Two select bits pick one of four inputs
// [R7] Select sampled on falling edge; change restarts
// [R8] First ready after change carries new input
// [R9] Ready withheld until five conversions after restart
// [R10] Host changes select only after reading result
// [R11] Bits leave on serial clock falling edge
// [R12] Bit pointer reset at each ready phase
// [R13] 384-cycle word counter cleared on restart
module cms_sequencer #(
  parameter int WORD_CYCLES = cms_pkg::WORD_CYC,
  parameter int SETTLE_COUNT = cms_pkg::SETTLE_WORDS
) (
  // System clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Modulator bitstream
  input wire logic mod_bit_in,
  // Channel select pins
  input wire logic input_select_high,
  input wire logic input_select_low,
  output logic [3:0] input_enable,
  // Serial link
  input wire logic sclk,
  output logic result_and_ready_line
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic mod_meta_r, mod_sync_r;
  logic [1:0] sel_meta_r, sel_sync_r, sel_prev_r;
  logic restart_r;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mod_meta_r <= 1'b0;
      mod_sync_r <= 1'b0;
    end else begin
      mod_meta_r <= mod_bit_in;
      mod_sync_r <= mod_meta_r;
    end
  end

  always_ff @(negedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sel_meta_r <= cms_pkg::SEL_RST;
      sel_sync_r <= cms_pkg::SEL_RST;
      sel_prev_r <= cms_pkg::SEL_RST;
      restart_r <= 1'b0;
    end else begin
      sel_meta_r <= {input_select_high, input_select_low};
      sel_sync_r <= sel_meta_r;
      sel_prev_r <= sel_sync_r;
      restart_r <= (sel_sync_r != sel_prev_r); // see [R7]
    end
  end

  // ****************************************
  // Channel decode
  // ****************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      input_enable <= cms_pkg::CH_ONEHOT_RST;
    end else begin
      input_enable <= 4'h1 << sel_prev_r; // see [R6]
    end
  end

  // ****************************************
  // Modulator divider and word counter
  // ****************************************
  localparam int WCNT_W = $clog2(WORD_CYCLES);
  logic [2:0] div_r;
  logic [WCNT_W-1:0] word_cnt_r;
  logic mod_tick, word_end;

  assign mod_tick = (div_r == 3'(cms_pkg::MOD_DIV - 1)); // see [R1]
  assign word_end = (word_cnt_r == WCNT_W'(WORD_CYCLES - 1)); // see [R2]

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= 3'h0;
    end else if (restart_r || mod_tick) begin
      div_r <= 3'h0;
    end else begin
      div_r <= div_r + 3'h1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      word_cnt_r <= '0;
    end else if (restart_r || word_end) begin
      word_cnt_r <= '0; // see [R13]
    end else begin
      word_cnt_r <= word_cnt_r + WCNT_W'(1);
    end
  end

  // ****************************************
  // Sinc decimator
  // ****************************************
  logic [cms_pkg::ACC_W-1:0] integ_r [cms_pkg::SINC_ORDER];
  logic [cms_pkg::ACC_W-1:0] delay_r [cms_pkg::SINC_ORDER];
  logic [cms_pkg::ACC_W-1:0] comb_v [cms_pkg::SINC_ORDER+1];
  logic [cms_pkg::RESULT_W-1:0] sinc_out;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < cms_pkg::SINC_ORDER; i++) begin
        integ_r[i] <= '0;
      end
    end else if (restart_r) begin
      for (int i = 0; i < cms_pkg::SINC_ORDER; i++) begin
        integ_r[i] <= '0;
      end
    end else if (mod_tick) begin
      integ_r[0] <= integ_r[0] + cms_pkg::ACC_W'(mod_sync_r); // see [R3]
      for (int i = 1; i < cms_pkg::SINC_ORDER; i++) begin
        integ_r[i] <= integ_r[i] + integ_r[i-1];
      end
    end
  end

  always_comb begin
    comb_v[0] = integ_r[cms_pkg::SINC_ORDER-1];
    for (int i = 0; i < cms_pkg::SINC_ORDER; i++) begin
      comb_v[i+1] = comb_v[i] - delay_r[i]; // see [R3]
    end
    if (comb_v[cms_pkg::SINC_ORDER][cms_pkg::ACC_W-1]) begin
      sinc_out = cms_pkg::RESULT_SAT;
    end else begin
      sinc_out = comb_v[cms_pkg::SINC_ORDER]
        [cms_pkg::ACC_W-2:cms_pkg::RES_LSB];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < cms_pkg::SINC_ORDER; i++) begin
        delay_r[i] <= '0;
      end
    end else if (restart_r) begin
      for (int i = 0; i < cms_pkg::SINC_ORDER; i++) begin
        delay_r[i] <= '0;
      end
    end else if (word_end) begin
      for (int i = 0; i < cms_pkg::SINC_ORDER; i++) begin
        delay_r[i] <= comb_v[i];
      end
    end
  end

  // ****************************************
  // Output word register and settling
  // ****************************************
  logic [cms_pkg::RESULT_W-1:0] output_word_register_r;
  logic [2:0] settle_r;
  logic settled;

  assign settled = (settle_r >= 3'(SETTLE_COUNT));

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      output_word_register_r <= cms_pkg::RESULT_RST;
    end else if (word_end && !restart_r) begin
      output_word_register_r <= sinc_out ^ cms_pkg::RESULT_SIGN; // see [R4]
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      settle_r <= 3'h0;
    end else if (restart_r) begin
      settle_r <= 3'h0; // see [R9]
    end else if (word_end && !settled) begin
      settle_r <= settle_r + 3'h1;
    end
  end

  // ****************************************
  // Ready phase sequencing
  // ****************************************
  cms_pkg::cms_phase_t phase_r;
  logic [2:0] ph_cnt_r;
  logic load_ok;

  assign load_ok = word_end && !restart_r &&
    (settle_r >= 3'(SETTLE_COUNT - 1));

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      phase_r <= cms_pkg::CMS_IDLE;
      ph_cnt_r <= 3'h0;
    end else if (restart_r) begin
      phase_r <= cms_pkg::CMS_IDLE; // see [R8]
      ph_cnt_r <= 3'h0;
    end else if (load_ok) begin
      phase_r <= cms_pkg::CMS_LOW; // see [R5]
      ph_cnt_r <= 3'h0;
    end else begin
      case (phase_r)
        cms_pkg::CMS_LOW: begin
          ph_cnt_r <= ph_cnt_r + 3'h1;
          if (ph_cnt_r == 3'(cms_pkg::READY_LOW_CYC - 1)) begin
            phase_r <= cms_pkg::CMS_HIGH;
            ph_cnt_r <= 3'h0;
          end
        end
        cms_pkg::CMS_HIGH: begin
          ph_cnt_r <= ph_cnt_r + 3'h1;
          if (ph_cnt_r == 3'(cms_pkg::READY_HIGH_CYC - 1)) begin
            phase_r <= cms_pkg::CMS_SHIFT;
            ph_cnt_r <= 3'h0;
          end
        end
        default: begin
          ph_cnt_r <= 3'h0;
        end
      endcase
    end
  end

  // ****************************************
  // Serial clock domain edge counter
  // ****************************************
  logic [cms_pkg::PTR_W-1:0] edge_bin_r, edge_gray_r;
  logic [cms_pkg::PTR_W-1:0] edge_bin_nxt;

  assign edge_bin_nxt = edge_bin_r + cms_pkg::PTR_W'(1);

  always_ff @(negedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      edge_bin_r <= '0;
      edge_gray_r <= '0;
    end else begin
      edge_bin_r <= edge_bin_nxt; // see [R11]
      edge_gray_r <= edge_bin_nxt ^ (edge_bin_nxt >> 1);
    end
  end

  // ****************************************
  // Edge count crossing and pointer base
  // ****************************************
  logic [cms_pkg::PTR_W-1:0] gray_meta_r, gray_sync_r, edge_mclk;
  logic [cms_pkg::PTR_W-1:0] base_r, bit_idx;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      gray_meta_r <= '0;
      gray_sync_r <= '0;
    end else begin
      gray_meta_r <= edge_gray_r;
      gray_sync_r <= gray_meta_r;
    end
  end

  always_comb begin
    edge_mclk[cms_pkg::PTR_W-1] = gray_sync_r[cms_pkg::PTR_W-1];
    for (int i = cms_pkg::PTR_W - 2; i >= 0; i--) begin
      edge_mclk[i] = edge_mclk[i+1] ^ gray_sync_r[i];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      base_r <= '0;
    end else if (phase_r != cms_pkg::CMS_SHIFT) begin
      base_r <= edge_mclk; // see [R12]
    end
  end

  // ****************************************
  // Result and ready line
  // ****************************************
  assign bit_idx = edge_bin_r - base_r; // see [R11]

  always_comb begin
    case (phase_r)
      cms_pkg::CMS_LOW: begin
        result_and_ready_line = 1'b0; // see [R5]
      end
      cms_pkg::CMS_SHIFT: begin
        if (bit_idx < cms_pkg::PTR_W'(cms_pkg::RESULT_W)) begin
          result_and_ready_line = output_word_register_r[
            5'(cms_pkg::RESULT_W - 1) - bit_idx[4:0]]; // see [R12]
        end else begin
          result_and_ready_line = 1'b0;
        end
      end
      default: begin
        result_and_ready_line = 1'b1;
      end
    endcase
  end

endmodule

// ---- dv/cms_sequencer_props.sv ----
`timescale 1ns/1ps
module cms_sequencer_props #(
  parameter int WORD_CYCLES = 384,
  parameter int SETTLE_COUNT = 5
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic mod_bit_in,
  input wire logic input_select_high,
  input wire logic input_select_low,
  input wire logic [3:0] input_enable,
  input wire logic sclk,
  input wire logic result_and_ready_line
);
  // ****
  // Helper counters
  // ****
  localparam int LIM = WORD_CYCLES * SETTLE_COUNT;
  logic [1:0] sel_r;
  logic sclk_r, line_r, seen_r, gv_r;
  int sq_r, rc_r, gap_r;
  wire [1:0] sel = {input_select_high, input_select_low};
  wire rs = sel != sel_r;
  wire rdy = result_and_ready_line && !line_r && sq_r >= 8 && rc_r > 8;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sel_r <= 2'h0;
      sclk_r <= 1'b0;
      line_r <= 1'b1;
      {seen_r, gv_r} <= 2'h0;
      {sq_r, rc_r, gap_r} <= '0;
    end else begin
      sel_r <= sel;
      sclk_r <= sclk;
      line_r <= result_and_ready_line;
      sq_r <= (sclk != sclk_r) ? 0 : (sq_r < 15) ? sq_r + 1 : sq_r;
      rc_r <= rs ? 0 : (rc_r < 4095) ? rc_r + 1 : rc_r;
      seen_r <= !rs && (seen_r || (rc_r > 8 && !result_and_ready_line));
      gv_r <= !rs && (gv_r || rdy);
      gap_r <= rdy ? 1 : gap_r + 1;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_onehot;
    $onehot(input_enable);
  endproperty
  a_onehot: assert property (p_onehot)
    else $error("enable not one-hot");
  property p_decode;
    $stable(sel) [*5] |-> input_enable == (4'h1 << sel);
  endproperty
  a_decode: assert property (p_decode)
    else $error("enable does not match select");
  property p_chg;
    $changed(input_enable) |-> rc_r <= 5;
  endproperty
  a_chg: assert property (p_chg)
    else $error("enable changed without select change");
  property p_hold;
    rc_r >= 8 && rc_r < LIM |-> result_and_ready_line;
  endproperty
  a_hold: assert property (p_hold)
    else $error("ready before settling");
  property p_first;
    rc_r == LIM + 8 |-> seen_r;
  endproperty
  a_first: assert property (p_first)
    else $error("first ready late");
  property p_period;
    rdy && gv_r |-> gap_r == WORD_CYCLES;
  endproperty
  a_period: assert property (p_period)
    else $error("word period wrong");
  property p_low4;
    rdy |-> !$past(result_and_ready_line) && !$past(result_and_ready_line, 4);
  endproperty
  a_low4: assert property (p_low4)
    else $error("ready low pulse short");
  property p_high2;
    rdy |=> result_and_ready_line;
  endproperty
  a_high2: assert property (p_high2)
    else $error("ready high phase short");
endmodule
bind cms_sequencer cms_sequencer_props #(
  .WORD_CYCLES(WORD_CYCLES),
  .SETTLE_COUNT(SETTLE_COUNT)
) props (
  .mclk(mclk),
  .rst_n(rst_n),
  .mod_bit_in(mod_bit_in),
  .input_select_high(input_select_high),
  .input_select_low(input_select_low),
  .input_enable(input_enable),
  .sclk(sclk),
  .result_and_ready_line(result_and_ready_line)
);

// ---- dv/cms_host_model.sv ----
`timescale 1ns/1ps
module cms_host_model (
  // Clock and line
  input wire logic mclk,
  input wire logic line,
  // Serial clock
  output logic sclk
);
  // ****
  // Word read, sclk idle low
  // ****
  initial sclk = 1'b0;
  task automatic read_word(output logic [23:0] w);
    repeat (4) @(posedge mclk);
    #3;
    for (int i = 23; i >= 0; i--) begin
      #24 w[i] = line;
      sclk = 1'b1;
      #24 sclk = 1'b0;
    end
  endtask
endmodule

// ---- dv/cms_sequencer_tb.sv ----
`timescale 1ns/1ps
module cms_sequencer_tb;
  localparam int LIM = cms_pkg::WORD_CYC * cms_pkg::SETTLE_WORDS;
  logic mclk, rst_n, mod_bit, sel_h, sel_l, sclk, line;
  logic [3:0] en;
  logic [23:0] w;
  int n_errors, total_checks, cyc, n;
  cms_sequencer dut (
    .mclk(mclk), .rst_n(rst_n), .mod_bit_in(mod_bit),
    .input_select_high(sel_h), .input_select_low(sel_l),
    .input_enable(en), .sclk(sclk), .result_and_ready_line(line));
  cms_host_model host (.mclk(mclk), .line(line), .sclk(sclk));
  // ****
  // Clock, timeout, helpers
  // ****
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      print_verdict();
    end
  end
  task automatic chk(string nm, logic [23:0] s, logic [23:0] e);
    total_checks++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic wait_rdy(output int k);
    k = 0;
    while (line !== 1'b0 && k < 3000) begin
      @(posedge mclk);
      k++;
    end
    while (line !== 1'b1 && k < 3000) begin
      @(posedge mclk);
      k++;
    end
  endtask
  task automatic set_sel(logic [1:0] s, logic m);
    @(posedge mclk);
    {sel_h, sel_l} <= s;
    mod_bit <= m;
    repeat (8) @(posedge mclk);
  endtask
  task automatic settle(string nm, logic [23:0] e);
    wait_rdy(n);
    chk(nm, n + 8 >= LIM && n + 8 <= LIM + 16, 1);
    host.read_word(w);
    chk(nm, w, e);
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_zero();
    chk("en_rst", en, cms_pkg::CH_ONEHOT_RST);
    chk("line_rst", line, 1);
    repeat (2) begin
      wait_rdy(n);
      host.read_word(w);
      chk("word0", w, cms_pkg::RESULT_SIGN);
    end
    $display("t_zero done");
  endtask
  task automatic t_chan();
    for (int s = 1; s <= 4; s++) begin
      set_sel(s[1:0], s[0]);
      chk("en", en, 4'h1 << s[1:0]);
      settle("chan", s[0] ? cms_pkg::RESULT_SAT ^ cms_pkg::RESULT_SIGN
                          : cms_pkg::RESULT_SIGN);
    end
    $display("t_chan done");
  endtask
  task automatic t_restart();
    set_sel(2'h1, 1'b1);
    repeat (1000) @(posedge mclk);
    set_sel(2'h2, 1'b0);
    settle("restart", cms_pkg::RESULT_SIGN);
    $display("t_restart done");
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    {mod_bit, sel_h, sel_l} = 3'h0;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    t_zero();
    t_chan();
    t_restart();
    print_verdict();
  end
endmodule
